// ==== inc/pawk_defines.svh ====
// Constants for the port pin control and wake-up block
// Function
// RL1: General pins work as digital input or push-pull output with optional pull-up.
// RL2: Port bit five drives only open-drain: pull low or release; input with pull-up.
// RL3: Cleared digital-input-enable bit blocks that pin's digital input path.
// RL4: Any pin wakes from sleep, but not when its digital-input-enable is zero.
// RL5: Port bit zero raises interrupt request on both rising and falling edges.
// RL6: Port bit zero can drive the comparator result as alternate function.
// RL7: Eight-bit timer PWM output can be routed to port bit four or three.
// RL8: Port bit five can serve as external hardware reset input.
// RL9: Bit four is comparator positive input; bits 7,6,4,3 selectable as negative.
// RL10: Fast wake-up resumes 32 slow oscillator periods after the wake event.
// RL11: Control bit set selects fast wake, cleared selects slow wake of 2048 periods.
// RL12: Wake-up is any change of an enabled synchronised pin level while sleeping.
`ifndef PAWK_DEFINES_SVH
`define PAWK_DEFINES_SVH

// ----------------------------------------
// Pin positions
// ----------------------------------------
`define PAWK_BIT_ZERO 0
`define PAWK_BIT_THREE 3
`define PAWK_BIT_FOUR 4
`define PAWK_BIT_FIVE 5
`define PAWK_BIT_SIX 6
`define PAWK_BIT_SEVEN 7
`define PAWK_PIN_MASK 8'hF9
`define PAWK_PORT_RESET 8'h00

// ----------------------------------------
// PWM routing and negative input select codes
// ----------------------------------------
`define PAWK_PWM_OFF 2'h0
`define PAWK_PWM_BIT4 2'h1
`define PAWK_PWM_BIT3 2'h2
`define PAWK_NEG_BIT7 2'h0
`define PAWK_NEG_BIT6 2'h1
`define PAWK_NEG_BIT4 2'h2
`define PAWK_NEG_BIT3 2'h3

// ----------------------------------------
// Wake-up delays in slow oscillator periods
// ----------------------------------------
`define PAWK_FAST_WAKE_PERIODS 32
`define PAWK_SLOW_WAKE_PERIODS 2048
`define PAWK_WAKE_CNT_W 12

`endif

// ==== inc/pawk_pkg.sv ====
// Types shared by the port pin control and wake-up block
package pawk_pkg;

    // Sleep and wake-up sequence states
    typedef enum logic [1:0] {
        WS_RUN,
        WS_SLEEP,
        WS_WAIT
    } pawk_wake_state_t;

endpackage

// ==== rtl/pawk_rst_sync.sv ====
// Reset release synchroniser, two flip-flops
`timescale 1ns/1ps
module pawk_rst_sync (
    // Clock and raw reset
    input wire logic clk,
    input wire logic rstRawN,
    // Synchronised reset
    output logic rstSyncN
);

    logic stage1Q;

    // Assert at once, release after two edges
    always_ff @(posedge clk or negedge rstRawN) begin
        if (!rstRawN) begin
            stage1Q <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            stage1Q <= 1'b1;
            rstSyncN <= stage1Q;
        end
    end

endmodule

// ==== rtl/pawk_top.sv ====
// Port pin control, alternate functions and sleep wake-up
`timescale 1ns/1ps
`include "pawk_defines.svh"
module pawk_top #(
    parameter int PORT_W = 8,
    parameter logic [11:0] FAST_PERIODS = 12'(`PAWK_FAST_WAKE_PERIODS),
    parameter logic [11:0] SLOW_PERIODS = 12'(`PAWK_SLOW_WAKE_PERIODS)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Port control from core
    input wire logic [PORT_W-1:0] dataOut,
    input wire logic [PORT_W-1:0] dirOut,
    input wire logic [PORT_W-1:0] pullUpEn,
    input wire logic [PORT_W-1:0] digInEn,
    // Alternate function control
    input wire logic compOutEn,
    input wire logic [1:0] pwmPinSel,
    input wire logic extResetEn,
    input wire logic compPosSel,
    input wire logic compNegEn,
    input wire logic [1:0] compNegSel,
    // Sleep and wake control
    input wire logic sleepReq,
    input wire logic wakeFast,
    input wire logic slowOscTick,
    // Signals from other blocks
    input wire logic comparatorResult,
    input wire logic timer8PwmOutput,
    // Pins
    input wire logic [PORT_W-1:0] padIn,
    output logic [PORT_W-1:0] padOut,
    output logic [PORT_W-1:0] padOe,
    output logic [PORT_W-1:0] padPullUp,
    // Analogue switch controls
    output logic compPosConnect,
    output logic [3:0] compNegConnect,
    // Status to core
    output logic [PORT_W-1:0] portDataIn,
    output logic extIntReq,
    output logic extResetReq,
    output logic sleeping,
    output logic wakeUp
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // One-hot switch for the negative comparator input
    function automatic logic [3:0] negDecode(input logic en, input logic [1:0] sel);
        logic [3:0] oneHot;
        oneHot = 4'h0;
        if (en) begin
            oneHot[sel] = 1'b1;
        end
        return oneHot;
    endfunction

    // ----------------------------------------
    // Reset
    // ----------------------------------------
    logic rstN;

    pawk_rst_sync u_rst (
        .clk(core_clk),
        .rstRawN(rst_n),
        .rstSyncN(rstN)
    );

    // ----------------------------------------
    // Pin input sampling
    // ----------------------------------------
    logic [PORT_W-1:0] pinInQ;
    logic [PORT_W-1:0] gatedIn;
    logic [PORT_W-1:0] gatedPrevQ;
    logic [PORT_W-1:0] pinMask;

    assign pinMask = PORT_W'(`PAWK_PIN_MASK);
    // Digital input path blocked where the enable is clear
    assign gatedIn = pinInQ & digInEn & pinMask; // [RL3]

    // Pin capture and previous level
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            pinInQ <= PORT_W'(`PAWK_PORT_RESET);
            gatedPrevQ <= PORT_W'(`PAWK_PORT_RESET);
        end else begin
            pinInQ <= padIn;
            gatedPrevQ <= gatedIn;
        end
    end

    // ----------------------------------------
    // Pin output drive
    // ----------------------------------------
    logic pwmOnFour;
    logic pwmOnThree;
    logic [PORT_W-1:0] padOutD;
    logic [PORT_W-1:0] padOeD;
    logic [PORT_W-1:0] padPullUpD;

    assign pwmOnFour = (pwmPinSel == `PAWK_PWM_BIT4); // [RL7]
    assign pwmOnThree = (pwmPinSel == `PAWK_PWM_BIT3); // [RL7]

    // Per-pin output value and enable with alternate functions
    always_comb begin
        padOutD = dataOut & pinMask; // [RL1]
        padOeD = dirOut & pinMask; // [RL1]
        if (compOutEn) begin
            padOutD[`PAWK_BIT_ZERO] = comparatorResult; // [RL6]
            padOeD[`PAWK_BIT_ZERO] = 1'b1; // [RL6]
        end
        if (pwmOnFour) begin
            padOutD[`PAWK_BIT_FOUR] = timer8PwmOutput; // [RL7]
            padOeD[`PAWK_BIT_FOUR] = 1'b1;
        end
        if (pwmOnThree) begin
            padOutD[`PAWK_BIT_THREE] = timer8PwmOutput; // [RL7]
            padOeD[`PAWK_BIT_THREE] = 1'b1;
        end
        // Bit five only pulls low or releases
        padOutD[`PAWK_BIT_FIVE] = 1'b0; // [RL2]
        padOeD[`PAWK_BIT_FIVE] = dirOut[`PAWK_BIT_FIVE]
            & ~dataOut[`PAWK_BIT_FIVE] & ~extResetEn; // [RL2] [RL8]
    end

    // Pull-ups selectable per pin
    assign padPullUpD = pullUpEn & pinMask; // [RL1] [RL2]

    // Registered pin drive
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            padOut <= PORT_W'(`PAWK_PORT_RESET);
            padOe <= PORT_W'(`PAWK_PORT_RESET);
            padPullUp <= PORT_W'(`PAWK_PORT_RESET);
        end else begin
            padOut <= padOutD;
            padOe <= padOeD;
            padPullUp <= padPullUpD;
        end
    end

    // ----------------------------------------
    // Comparator inputs, interrupt and reset pin
    // ----------------------------------------
    logic intEdge;
    logic extResetD;

    // Either edge of bit zero requests an interrupt
    assign intEdge = gatedIn[`PAWK_BIT_ZERO] ^ gatedPrevQ[`PAWK_BIT_ZERO]; // [RL5]
    // Active-low reset from bit five when enabled
    assign extResetD = extResetEn & ~pinInQ[`PAWK_BIT_FIVE]; // [RL8]

    // Status and analogue switch flops
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            portDataIn <= PORT_W'(`PAWK_PORT_RESET);
            extIntReq <= 1'b0;
            extResetReq <= 1'b0;
            compPosConnect <= 1'b0;
            compNegConnect <= 4'h0;
        end else begin
            portDataIn <= gatedIn; // [RL3]
            extIntReq <= intEdge; // [RL5]
            extResetReq <= extResetD; // [RL8]
            compPosConnect <= compPosSel; // [RL9]
            compNegConnect <= negDecode(compNegEn, compNegSel); // [RL9]
        end
    end

    // ----------------------------------------
    // Sleep and wake-up sequence
    // ----------------------------------------
    pawk_pkg::pawk_wake_state_t stateQ;
    pawk_pkg::pawk_wake_state_t stateD;
    logic [PORT_W-1:0] wakeChange;
    logic wakeEvent;
    logic cntStart;
    logic cntBusy;
    logic cntDone;

    // Changes on enabled pins only
    assign wakeChange = (gatedIn ^ gatedPrevQ) & digInEn & pinMask; // [RL4] [RL12]
    assign wakeEvent = (stateQ == pawk_pkg::WS_SLEEP) && (|wakeChange); // [RL12]
    assign cntStart = wakeEvent; // [RL12]

    pawk_wake_cnt #(
        .CNT_W(`PAWK_WAKE_CNT_W),
        .FAST_PERIODS(FAST_PERIODS),
        .SLOW_PERIODS(SLOW_PERIODS)
    ) u_cnt (
        .clk(core_clk),
        .rstN(rstN),
        .start(cntStart),
        .fastSel(wakeFast), // [RL10] [RL11]
        .slowTick(slowOscTick),
        .busy(cntBusy),
        .done(cntDone)
    );

    // Next state of the sleep sequence
    always_comb begin
        stateD = stateQ;
        case (stateQ)
            pawk_pkg::WS_RUN: begin
                if (sleepReq) begin
                    stateD = pawk_pkg::WS_SLEEP;
                end
            end
            pawk_pkg::WS_SLEEP: begin
                if (wakeEvent) begin
                    stateD = pawk_pkg::WS_WAIT; // [RL4]
                end
            end
            pawk_pkg::WS_WAIT: begin
                if (cntDone) begin
                    stateD = pawk_pkg::WS_RUN; // [RL10] [RL11]
                end
            end
            default: begin
                stateD = pawk_pkg::WS_RUN;
            end
        endcase
    end

    // State and wake outputs
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            stateQ <= pawk_pkg::WS_RUN;
            sleeping <= 1'b0;
            wakeUp <= 1'b0;
        end else begin
            stateQ <= stateD;
            sleeping <= (stateD != pawk_pkg::WS_RUN);
            wakeUp <= (stateQ == pawk_pkg::WS_WAIT) && cntDone;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [12:0] ticksSeenQ;
    logic fastAtStartQ;

    // Slow periods seen during the wake delay
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ticksSeenQ <= 13'h0000;
            fastAtStartQ <= 1'b0;
        end else if (cntStart) begin
            ticksSeenQ <= 13'h0000;
            fastAtStartQ <= wakeFast;
        end else if (cntBusy && slowOscTick) begin
            ticksSeenQ <= ticksSeenQ + 13'h0001;
        end
    end

    sequence s_sleep_change;
        (stateQ == pawk_pkg::WS_SLEEP) && (|wakeChange);
    endsequence

    sequence s_waiting;
        (stateQ == pawk_pkg::WS_WAIT) && cntBusy;
    endsequence

    a_wake_detect: assert property (@(posedge core_clk) disable iff (!rstN) // [RL12]
        s_sleep_change |=> s_waiting)
        else $error("Wake change did not start the delay");

    a_wake_ignore: assert property (@(posedge core_clk) disable iff (!rstN) // [RL4]
        (stateQ == pawk_pkg::WS_SLEEP) && !(|wakeChange) |=> stateQ == pawk_pkg::WS_SLEEP)
        else $error("Left sleep without an enabled pin change");

    a_fast_delay: assert property (@(posedge core_clk) disable iff (!rstN) // [RL10]
        $rose(wakeUp) && fastAtStartQ |-> ticksSeenQ == 13'(FAST_PERIODS))
        else $error("Fast wake delay has wrong length");

    a_slow_delay: assert property (@(posedge core_clk) disable iff (!rstN) // [RL11]
        $rose(wakeUp) && !fastAtStartQ |-> ticksSeenQ == 13'(SLOW_PERIODS))
        else $error("Slow wake delay has wrong length");

    a_push_pull: assert property (@(posedge core_clk) disable iff (!rstN) // [RL1]
        dirOut[`PAWK_BIT_SEVEN] |=> padOe[`PAWK_BIT_SEVEN]
            && padOut[`PAWK_BIT_SEVEN] == $past(dataOut[`PAWK_BIT_SEVEN]))
        else $error("Push-pull pin not driven");

    a_open_drain: assert property (@(posedge core_clk) disable iff (!rstN) // [RL2]
        !padOut[`PAWK_BIT_FIVE])
        else $error("Bit five driven high");

    a_input_block: assert property (@(posedge core_clk) disable iff (!rstN) // [RL3]
        ##1 (portDataIn & ~$past(digInEn)) == PORT_W'(`PAWK_PORT_RESET))
        else $error("Blocked input seen by core");

    a_int_edge: assert property (@(posedge core_clk) disable iff (!rstN) // [RL5]
        $changed(gatedIn[`PAWK_BIT_ZERO]) |=> extIntReq)
        else $error("Edge on bit zero gave no interrupt");

    a_comp_route: assert property (@(posedge core_clk) disable iff (!rstN) // [RL6]
        compOutEn |=> padOe[`PAWK_BIT_ZERO]
            && padOut[`PAWK_BIT_ZERO] == $past(comparatorResult))
        else $error("Comparator result not on bit zero");

    a_pwm_route: assert property (@(posedge core_clk) disable iff (!rstN) // [RL7]
        pwmOnThree |=> padOe[`PAWK_BIT_THREE]
            && padOut[`PAWK_BIT_THREE] == $past(timer8PwmOutput))
        else $error("PWM not on bit three");

    a_reset_pin: assert property (@(posedge core_clk) disable iff (!rstN) // [RL8]
        extResetEn && !pinInQ[`PAWK_BIT_FIVE] |=> extResetReq && !padOe[`PAWK_BIT_FIVE])
        else $error("Reset pin not honoured");

    a_neg_select: assert property (@(posedge core_clk) disable iff (!rstN) // [RL9]
        compNegEn && compNegSel == `PAWK_NEG_BIT3 |=> compNegConnect == 4'h8)
        else $error("Negative input select wrong");

endmodule

// ==== rtl/pawk_wake_cnt.sv ====
// Wake-up delay counter in slow oscillator periods
`timescale 1ns/1ps
module pawk_wake_cnt #(
    parameter int CNT_W = 12,
    parameter logic [11:0] FAST_PERIODS = 12'h020,
    parameter logic [11:0] SLOW_PERIODS = 12'h800
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Control
    input wire logic start,
    input wire logic fastSel,
    input wire logic slowTick,
    // Status
    output logic busy,
    output logic done
);

    logic [CNT_W-1:0] remainQ;
    logic [CNT_W-1:0] remainD;
    logic lastTick;

    // Last period of the delay
    assign lastTick = busy && slowTick && (remainQ == CNT_W'(1));

    // Load on start, count down on each slow period
    always_comb begin
        remainD = remainQ;
        if (start) begin
            remainD = fastSel ? CNT_W'(FAST_PERIODS) : CNT_W'(SLOW_PERIODS);
        end else if (busy && slowTick) begin
            remainD = remainQ - CNT_W'(1);
        end
    end

    // Counter and status flops
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            remainQ <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            remainQ <= remainD;
            busy <= start | (busy & ~lastTick);
            done <= lastTick & ~start;
        end
    end

endmodule

// ==== testbench/pawk_board_model.sv ====
// Board model: resolves pin levels from device drive, board drive and pull-ups
`timescale 1ns/1ps
module pawk_board_model (
    // Clock
    input wire logic clk,
    // Device side of the pins
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    input wire logic [7:0] padPullUp,
    // Board drivers
    input wire logic [7:0] boardVal,
    input wire logic [7:0] boardEn,
    // Resolved pin levels
    output logic [7:0] padIn
);
    logic [7:0] floatQ = 8'h00;

    // Undriven pins without pull-up wander each cycle
    always @(posedge clk) begin
        floatQ <= ~floatQ;
    end

    // Device wins, then board, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (padOe[i]) padIn[i] = padOut[i];
            else if (boardEn[i]) padIn[i] = boardVal[i];
            else if (padPullUp[i]) padIn[i] = 1'b1;
            else padIn[i] = floatQ[i];
        end
    end
endmodule

// ==== testbench/tb_port_a_pin_control_wakeup.sv ====
// Self-checking bench for the port pin control and wake-up block
`timescale 1ns/1ps
module tb_port_a_pin_control_wakeup;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int FAST = 2;
    localparam int SLOW = 8;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] dataOut = 8'h00, dirOut = 8'h00, pullUpEn = 8'h00, digInEn = 8'h00;
    logic compOutEn = 1'b0, extResetEn = 1'b0, compPosSel = 1'b0, compNegEn = 1'b0;
    logic [1:0] pwmPinSel = 2'h0, compNegSel = 2'h0;
    logic sleepReq = 1'b0, wakeFast = 1'b0, slowOscTick = 1'b0;
    logic comparatorResult = 1'b0, timer8PwmOutput = 1'b0;
    logic [7:0] boardVal = 8'hFF, boardEn = 8'hFF;
    logic [7:0] padIn, padOut, padOe, padPullUp, portDataIn;
    logic compPosConnect, extIntReq, extResetReq, sleeping, wakeUp;
    logic [3:0] compNegConnect;
    int mismatches = 0;
    int nTests = 0;
    int wakes = 0;

    // Clock and wake pulse counter
    always #12.5 core_clk = ~core_clk;
    always @(negedge core_clk) if (wakeUp === 1'b1) wakes++;

    pawk_top #(.FAST_PERIODS(12'h002), .SLOW_PERIODS(12'h008)) pawk_top_i (
        .core_clk(core_clk), .rst_n(rst_n), .dataOut(dataOut), .dirOut(dirOut),
        .pullUpEn(pullUpEn), .digInEn(digInEn), .compOutEn(compOutEn),
        .pwmPinSel(pwmPinSel), .extResetEn(extResetEn), .compPosSel(compPosSel),
        .compNegEn(compNegEn), .compNegSel(compNegSel), .sleepReq(sleepReq),
        .wakeFast(wakeFast), .slowOscTick(slowOscTick),
        .comparatorResult(comparatorResult), .timer8PwmOutput(timer8PwmOutput),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
        .compPosConnect(compPosConnect), .compNegConnect(compNegConnect),
        .portDataIn(portDataIn), .extIntReq(extIntReq), .extResetReq(extResetReq),
        .sleeping(sleeping), .wakeUp(wakeUp));

    pawk_board_model pawk_board_model_i (
        .clk(core_clk), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
        .boardVal(boardVal), .boardEn(boardEn), .padIn(padIn));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        nTests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Counts interrupt pulses over n cycles
    task automatic count_int(input int n, inout int c);
        repeat (n) begin
            cyc(1);
            if (extIntReq === 1'b1) c++;
        end
    endtask

    task automatic tick();
        slowOscTick = 1'b1;
        cyc(1);
        slowOscTick = 1'b0;
        cyc(2);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_drive();
        dirOut = 8'hFF;
        dataOut = 8'hD9;
        pullUpEn = 8'hFF;
        digInEn = 8'hFF;
        cyc(1);
        chk("padOe", padOe, 8'hF9);
        chk("padOut", padOut, 8'hD9);
        chk("padPullUp", padPullUp, 8'hF9);
        boardEn = 8'hDF;
        dataOut = 8'hFF;
        cyc(1);
        chk("padOe released", padOe, 8'hD9);
        chk("padOut", padOut, 8'hD9);
        cyc(2);
        chk("bit5 pulled up", portDataIn & 8'h20, 8'h20);
        dataOut = 8'hD9;
        cyc(3);
        chk("bit5 pulled low", portDataIn & 8'h20, 8'h00);
        boardEn = 8'hFF;
    endtask

    task automatic t_input();
        dirOut = 8'h00;
        boardVal = 8'hFF;
        digInEn = 8'h58;
        cyc(3);
        chk("portDataIn", portDataIn, 8'h58);
        digInEn = 8'h00;
        cyc(2);
        chk("portDataIn blocked", portDataIn, 8'h00);
    endtask

    task automatic t_extint();
        int c;
        c = 0;
        digInEn = 8'hFF;
        boardVal = 8'hFE;
        cyc(4);
        boardVal = 8'hFF;
        cyc(1);
        boardVal = 8'hFE;
        count_int(6, c);
        chk("edge pulses", c, 2);
        c = 0;
        digInEn = 8'hFE;
        cyc(4);
        boardVal = 8'hFF;
        count_int(6, c);
        chk("blocked pulses", c, 0);
    endtask

    task automatic t_alt();
        // Output data cleared so only the routed PWM shows on bits 3 and 4
        dirOut = 8'h00;
        dataOut = 8'h00;
        compOutEn = 1'b1;
        comparatorResult = 1'b1;
        cyc(1);
        chk("comp drive", {padOe[0], padOut[0]}, 2'h3);
        comparatorResult = 1'b0;
        cyc(1);
        chk("comp drive", {padOe[0], padOut[0]}, 2'h2);
        compOutEn = 1'b0;
        for (int s = 0; s < 4; s++) begin
            pwmPinSel = 2'(s);
            timer8PwmOutput = 1'b1;
            cyc(1);
            chk("pwm oe", padOe & 8'h18, s == 1 ? 8'h10 : s == 2 ? 8'h08 : 8'h00);
            chk("pwm out", padOut & 8'h18, s == 1 ? 8'h10 : s == 2 ? 8'h08 : 8'h00);
            timer8PwmOutput = 1'b0;
            cyc(1);
            chk("pwm low", padOut & 8'h18, 8'h00);
            compNegEn = 1'b1;
            compNegSel = 2'(s);
            compPosSel = s[0];
            cyc(1);
            chk("neg select", compNegConnect, 4'h1 << s);
            chk("pos select", compPosConnect, s[0]);
        end
        compNegEn = 1'b0;
        cyc(1);
        chk("neg off", compNegConnect, 4'h0);
    endtask

    task automatic t_extrst();
        extResetEn = 1'b1;
        dirOut = 8'h20;
        dataOut = 8'h00;
        boardVal = 8'hDF;
        cyc(3);
        chk("bit5 oe", padOe[5], 1'b0);
        chk("reset req", extResetReq, 1'b1);
        boardVal = 8'hFF;
        cyc(3);
        chk("reset req", extResetReq, 1'b0);
        extResetEn = 1'b0;
        dirOut = 8'h00;
    endtask

    task automatic t_wake(input logic fast, input int n);
        int w0;
        int k;
        boardVal = 8'hFF;
        digInEn = 8'hF1;
        wakeFast = fast;
        cyc(4);
        sleepReq = 1'b1;
        cyc(1);
        sleepReq = 1'b0;
        chk("sleeping", sleeping, 1'b1);
        w0 = wakes;
        boardVal = 8'hF7;
        cyc(4);
        repeat (n + 2) tick();
        chk("disabled pin wake", wakes - w0, 0);
        boardVal = 8'hE7;
        cyc(4);
        repeat (n - 1) tick();
        chk("early wake", wakes - w0, 0);
        chk("still asleep", sleeping, 1'b1);
        slowOscTick = 1'b1;
        cyc(1);
        slowOscTick = 1'b0;
        k = 0;
        while (wakes == w0 && k < 4) begin
            cyc(1);
            k++;
        end
        chk("wake count", wakes - w0, 1);
        chk("awake", sleeping, 1'b0);
        // A wake that never came ends the run here
        if (wakes == w0) begin
            stop_test();
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(5);
        chk("reset oe", padOe, 8'h00);
        chk("reset sleep", sleeping, 1'b0);
        rst_n = 1'b1;
        cyc(3);
        t_drive();
        t_input();
        t_extint();
        t_alt();
        t_extrst();
        t_wake(1'b1, FAST);
        t_wake(1'b0, SLOW);
        stop_test();
    end

    // Hang guard
    initial begin
        #2000000;
        mismatches++;
        stop_test();
    end
endmodule
